// *** verilog/fault_sd_consts.svh ***
// Purpose: named constants for the fault shutdown and restart block
// Assumes: pclk at 100 MHz
// Notes: register offsets are byte addresses on APB
`ifndef FAULT_SD_CONSTS_SVH
`define FAULT_SD_CONSTS_SVH

`define NUM_CH 5
`define CH_EXT 4
`define CLK_MHZ 100
// Fault deglitch time in ns, and the cycle count derived from it
`define FAULT_DEGLITCH_NS 500
`define FAULT_DEGLITCH_CYC ((`FAULT_DEGLITCH_NS * `CLK_MHZ) / 1000)
// Longest shutdown delay in ns, rounded down to cycles
`define FAULT_SD_DELAY_NS 4500
`define FAULT_SD_DELAY_CYC ((`FAULT_SD_DELAY_NS * `CLK_MHZ) / 1000)
// Autorestart wait in ns and cycles
`define AUTORESTART_NS 40960
`define AUTORESTART_CYC ((`AUTORESTART_NS * `CLK_MHZ) / 1000)

`define ADDR_CTRL 12'h000
`define ADDR_ON 12'h004
`define ADDR_INEN 12'h008
`define ADDR_QSTAT 12'h00c
`define ADDR_CHSTAT 12'h010
`define ADDR_IRQ_STAT 12'h014
`define ADDR_IRQ_MASK 12'h018
`define ADDR_DRIVE 12'h01c

`define CTRL_FAIL_BIT 0
`define CTRL_HID_LSB 1
`define CTRL_RESET 3'h0
`define DEG_W 8
`define RST_W 16

`endif

// *** verilog/fault_sd_pkg.sv ***
// Purpose: types for the fault shutdown and restart block
// Assumes: fault_sd_consts.svh defines the channel count
// Notes: channel status is a packed struct of fault sources
package fault_sd_pkg;
	typedef struct packed {
		logic supply_undervoltage;
		logic high_current_window_first;
		logic high_current_window_second;
		logic high_current_window_third;
		logic low_overcurrent_threshold;
		logic channel_overtemp;
		logic severe_short_detect;
	} fault_src_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ON = 2'b01,
		ST_FAULT = 2'b11,
		ST_LATCH = 2'b10
	} ch_state_t;
endpackage

// *** verilog/fault_deglitch.sv ***
// Purpose: fault deglitch filter for one channel
// Assumes: fault input already synchronised
// Notes: output rises only after the input stays high for the full count
`timescale 1ns/1ps
`include "fault_sd_consts.svh"
module fault_deglitch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fault_in,
	output logic fault_out
);
	logic [`DEG_W-1:0] cnt_reg;
	wire at_end = (cnt_reg == `DEG_W'(`FAULT_DEGLITCH_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			fault_out <= 1'b0;
		end else if (!fault_in) begin
			cnt_reg <= '0;
			fault_out <= 1'b0;
		end else if (at_end) begin
			fault_out <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + `DEG_W'(1);
		end
	end
endmodule // fault_deglitch

// *** verilog/channel_ctrl.sv ***
// Purpose: shutdown, restart and latch state of one channel
// Assumes: fault is already deglitched; fail_mode synchronous
// Notes: state is kept per channel, faults do not spread
`timescale 1ns/1ps
`include "fault_sd_consts.svh"
module channel_ctrl
	import fault_sd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fail_mode,
	input wire logic demand,
	input wire logic set_ev,
	input wire logic rewrite_ev,
	input wire logic fault,
	input wire logic fault_auto,
	output logic drive,
	output logic fast_off,
	output ch_state_t state
);
	ch_state_t state_reg, state_next;
	logic [`RST_W-1:0] wait_reg;
	logic fail_q;
	wire mode_chg = fail_q != fail_mode;
	wire wait_done = (wait_reg == `RST_W'(`AUTORESTART_CYC - 1));

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: begin
				// Fail mode follows the input level, not only its edge
				if ((set_ev || (fail_mode && demand)) && !fault)
					state_next = ST_ON;
			end
			ST_ON: begin
				if (fault)
					state_next = (fail_mode && !fault_auto) ? ST_LATCH : ST_FAULT;
				else if (!demand)
					state_next = ST_OFF;
			end
			ST_FAULT: begin
				if (mode_chg)
					state_next = ST_OFF;
				else if (!fail_mode && (set_ev || rewrite_ev) && !fault)
					state_next = ST_ON;
				else if (fail_mode && wait_done && !fault && demand)
					state_next = ST_ON;
			end
			ST_LATCH: if (mode_chg) state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_OFF;
			wait_reg <= '0;
			fail_q <= 1'b0;
			fast_off <= 1'b0;
		end else begin
			state_reg <= state_next;
			fail_q <= fail_mode;
			if (state_reg != ST_FAULT || wait_done)
				wait_reg <= '0;
			else
				wait_reg <= wait_reg + `RST_W'(1);
			// Held until restart so it survives supply loss
			if (fault)
				fast_off <= 1'b1;
			else if (state_next == ST_ON)
				fast_off <= 1'b0;
		end
	end

	assign drive = (state_reg == ST_ON) && demand && !fault;
	assign state = state_reg;
endmodule // channel_ctrl

// *** verilog/fault_shutdown.sv ***
// Purpose: per-channel fault shutdown and restart with APB registers
// Assumes: pins are asynchronous and pass two flip-flops
// Notes: channel index 4 is the external channel
`timescale 1ns/1ps
`include "fault_sd_consts.svh"

module fault_shutdown
	import fault_sd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] deglitched_control_input,
	input wire logic supply_undervoltage,
	input wire logic charge_pump_failure,
	input wire logic overtemp_shutdown,
	input wire logic [`NUM_CH-1:0] offstate_open_load,
	input wire logic [`NUM_CH-1:0] high_current_window_first,
	input wire logic [`NUM_CH-1:0] high_current_window_second,
	input wire logic [`NUM_CH-1:0] high_current_window_third,
	input wire logic [`NUM_CH-1:0] low_overcurrent_threshold,
	input wire logic [`NUM_CH-1:0] channel_overtemp,
	input wire logic [`NUM_CH-1:0] severe_short_detect,
	input wire logic [`NUM_CH-1:0] load_current_present,
	output logic [`NUM_CH-1:0] channel_drive_command,
	output logic [`NUM_CH-1:0] fast_turnoff_path,
	output logic [`NUM_CH-1:0] second_window_slow,
	output logic irq
);
	localparam int N = `NUM_CH;
	localparam int SW = 8 * N + 7;

	// Two-stage synchronisers for all pin inputs
	wire [SW-1:0] raw = {deglitched_control_input, supply_undervoltage,
		charge_pump_failure, overtemp_shutdown, offstate_open_load,
		high_current_window_first, high_current_window_second,
		high_current_window_third, low_overcurrent_threshold,
		channel_overtemp, severe_short_detect, load_current_present};
	logic [SW-1:0] sync1_reg, sync2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
		end
	end

	wire [3:0] din_s;
	wire undervolt_s, pump_fail_s, hot_shut_s;
	wire [N-1:0] olo_s, w1_s, w2_s, w3_s, low_oc_s, ot_s, ssc_s, load_s;
	assign {din_s, undervolt_s, pump_fail_s, hot_shut_s, olo_s, w1_s, w2_s,
		w3_s, low_oc_s, ot_s, ssc_s, load_s} = sync2_reg;

	// Registers
	logic [2:0] ctrl_reg;
	logic [N-1:0] on_reg, inen_reg, chstat_reg, irq_stat_reg, irq_mask_reg;
	logic [N-1:0] on_wr_pulse;
	logic [N-1:0] on_q, din_q;
	wire fail_mode = ctrl_reg[`CTRL_FAIL_BIT];
	wire [1:0] hid_sel = ctrl_reg[`CTRL_HID_LSB+1:`CTRL_HID_LSB];

	wire wr_en = psel && penable && pwrite;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction
	wire wr_ctrl = wr_en && hit(paddr, `ADDR_CTRL);
	wire wr_on = wr_en && hit(paddr, `ADDR_ON);
	wire wr_inen = wr_en && hit(paddr, `ADDR_INEN);
	wire wr_istat = wr_en && hit(paddr, `ADDR_IRQ_STAT);
	wire wr_imask = wr_en && hit(paddr, `ADDR_IRQ_MASK);
	wire mapped = hit(paddr, `ADDR_CTRL) || hit(paddr, `ADDR_ON) ||
		hit(paddr, `ADDR_INEN) || hit(paddr, `ADDR_QSTAT) ||
		hit(paddr, `ADDR_CHSTAT) || hit(paddr, `ADDR_IRQ_STAT) ||
		hit(paddr, `ADDR_IRQ_MASK) || hit(paddr, `ADDR_DRIVE);

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Per-channel fault and demand
	wire [N-1:0] fault_raw, fault_dg, fault_auto, demand, din_ext;
	wire [N-1:0] set_ev, rewrite_ev, ch_fault_ev;
	ch_state_t ch_state [N];
	assign din_ext = {1'b0, din_s};

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			assign fault_raw[g] = undervolt_s | w1_s[g] | w2_s[g] | w3_s[g] |
				low_oc_s[g] | ot_s[g] | ssc_s[g] | pump_fail_s | hot_shut_s |
				(olo_s[g] & ~channel_drive_command[g]);
			// Auto-restart class; others latch in fail mode
			assign fault_auto[g] = ~(w1_s[g] | ot_s[g] | ssc_s[g] |
				hot_shut_s);
			if (g == `CH_EXT) begin : g_ext
				assign demand[g] = fail_mode ? 1'b0 : on_reg[g];
			end else begin : g_pwr
				assign demand[g] = fail_mode ? din_ext[g] :
					(on_reg[g] | (inen_reg[g] & din_ext[g]));
			end
			assign set_ev[g] = (on_reg[g] & ~on_q[g]) |
				(din_ext[g] & ~din_q[g]);
			assign rewrite_ev[g] = on_wr_pulse[g] & on_reg[g];
			// Slow when no load current; fail mode slows every channel
			assign second_window_slow[g] = ~load_s[g] & (fail_mode ||
				hid_sel == 2'h0 || (hid_sel == 2'h1 && g == 2) ||
				(hid_sel == 2'h2 && (g == 2 || g == 3)));

			fault_deglitch u_deg (
				.pclk(pclk),
				.presetn(presetn),
				.fault_in(fault_raw[g]),
				.fault_out(fault_dg[g])
			);

			channel_ctrl u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.fail_mode(fail_mode),
				.demand(demand[g]),
				.set_ev(set_ev[g]),
				.rewrite_ev(rewrite_ev[g]),
				.fault(fault_dg[g]),
				.fault_auto(fault_auto[g]),
				.drive(channel_drive_command[g]),
				.fast_off(fast_turnoff_path[g]),
				.state(ch_state[g])
			);
			assign ch_fault_ev[g] = fault_dg[g] &&
				(ch_state[g] == ST_ON);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET;
			on_reg <= '0;
			inen_reg <= '0;
			irq_mask_reg <= '0;
			on_wr_pulse <= '0;
			on_q <= '0;
			din_q <= '0;
		end else begin
			on_q <= on_reg;
			din_q <= din_ext;
			on_wr_pulse <= wr_on ? pwdata[N-1:0] : '0;
			if (wr_ctrl)
				ctrl_reg <= pwdata[2:0];
			if (wr_on)
				on_reg <= pwdata[N-1:0];
			if (wr_inen)
				inen_reg <= {1'b0, pwdata[3:0]};
			if (wr_imask)
				irq_mask_reg <= pwdata[N-1:0];
		end
	end

	// Sticky status; a new fault wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chstat_reg <= '0;
			irq_stat_reg <= '0;
		end else begin
			chstat_reg <= (chstat_reg & ~(wr_istat ? pwdata[N-1:0] : '0)) |
				(fail_mode ? '0 : ch_fault_ev);
			irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? pwdata[N-1:0] : '0))
				| ch_fault_ev;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	wire [31:0] rd_mux =
		hit(paddr, `ADDR_CTRL) ? {29'h0, ctrl_reg} :
		hit(paddr, `ADDR_ON) ? {27'h0, on_reg} :
		hit(paddr, `ADDR_INEN) ? {27'h0, inen_reg} :
		hit(paddr, `ADDR_QSTAT) ? {31'h0, |chstat_reg} :
		hit(paddr, `ADDR_CHSTAT) ? {27'h0, chstat_reg} :
		hit(paddr, `ADDR_IRQ_STAT) ? {27'h0, irq_stat_reg} :
		hit(paddr, `ADDR_IRQ_MASK) ? {27'h0, irq_mask_reg} :
		hit(paddr, `ADDR_DRIVE) ? {22'h0, fast_turnoff_path,
			channel_drive_command} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end
endmodule // fault_shutdown

// *** testbench/fault_sd_assertions.sv ***
// Purpose: port checks for the fault shutdown block
// Assumes: zero-wait APB, deglitch far below the shutdown limit
// Notes: bound to every instance at the foot of the file
`timescale 1ns/1ps
`include "fault_sd_consts.svh"
module fault_sd_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic supply_undervoltage,
	input wire logic [`NUM_CH-1:0] high_current_window_first,
	input wire logic [`NUM_CH-1:0] high_current_window_second,
	input wire logic [`NUM_CH-1:0] high_current_window_third,
	input wire logic [`NUM_CH-1:0] low_overcurrent_threshold,
	input wire logic [`NUM_CH-1:0] channel_overtemp,
	input wire logic [`NUM_CH-1:0] severe_short_detect,
	input wire logic [`NUM_CH-1:0] channel_drive_command,
	input wire logic [`NUM_CH-1:0] fast_turnoff_path,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire f0 = supply_undervoltage | high_current_window_first[0]
		| high_current_window_second[0] | high_current_window_third[0]
		| low_overcurrent_threshold[0] | channel_overtemp[0]
		| severe_short_detect[0];
	logic [8:0] f0_cnt, undervolt_cnt;
	// Saturating run lengths of a held fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f0_cnt <= 9'h0;
			undervolt_cnt <= 9'h0;
		end else begin
			f0_cnt <= f0 ? f0_cnt + {8'h0, f0_cnt != 9'h1ff} : 9'h0;
			undervolt_cnt <= supply_undervoltage ?
				undervolt_cnt + {8'h0, undervolt_cnt != 9'h1ff} : 9'h0;
		end
	end
	AST_PREADY: assert property (acc |-> pready)
		else $error("pready low in access phase");
	AST_UNMAPPED: assert property (acc && paddr > `ADDR_DRIVE |-> pslverr)
		else $error("no error on unmapped address");
	AST_MAPPED: assert property (acc && paddr[1:0] == 2'h0
		&& paddr <= `ADDR_DRIVE |-> !pslverr)
		else $error("error on mapped address");
	AST_SLVERR_IDLE: assert property (!acc |-> !pslverr)
		else $error("error outside access phase");
	AST_FAST_OFF: assert property (
		(fast_turnoff_path & channel_drive_command) == 5'h0)
		else $error("driven while fast turn-off active");
	AST_SD_LIMIT: assert property (
		f0_cnt >= 9'd450 |-> !channel_drive_command[0])
		else $error("channel 0 on past shutdown limit");
	AST_UV_ALL: assert property (
		undervolt_cnt >= 9'd450 |-> channel_drive_command == 5'h0)
		else $error("channel on in long undervoltage");
	AST_RESET_QUIET: assert property ($rose(presetn) |->
		channel_drive_command == 5'h0 && !irq)
		else $error("outputs active after reset");
endmodule // fault_sd_assertions

bind fault_shutdown fault_sd_assertions chk (.pclk, .presetn, .psel,
	.penable, .paddr, .pready, .pslverr, .supply_undervoltage,
	.high_current_window_first, .high_current_window_second,
	.high_current_window_third, .low_overcurrent_threshold,
	.channel_overtemp, .severe_short_detect, .channel_drive_command,
	.fast_turnoff_path, .irq);

// *** testbench/lamp_load.sv ***
// Purpose: lamp loads on the power outputs
// Assumes: a shorted lamp overloads only while its switch conducts
// Notes: no current and no overload on an open switch
`timescale 1ns/1ps
`include "fault_sd_consts.svh"
module lamp_load (
	input wire logic [`NUM_CH-1:0] drive,
	input wire logic [`NUM_CH-1:0] short_cmd,
	output logic [`NUM_CH-1:0] current_present,
	output logic [`NUM_CH-1:0] overcurrent
);
	assign current_present = drive;
	assign overcurrent = drive & short_cmd;
endmodule // lamp_load

// *** testbench/tb_output_fault_shutdown_restart.sv ***
// Purpose: self-checking bench for the fault shutdown block
// Assumes: zero-wait APB slave, 100 MHz clock
// Notes: expected drive tracked in exp
`timescale 1ns/1ps
`include "fault_sd_consts.svh"
module tb_output_fault_shutdown_restart;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, irq, er, ref_pwm = 0;
	logic [2:0] shf = 0;
	logic [4:0] olo = 0, sws;
	logic [3:0] din = 0;
	logic [4:0] src [6] = '{default: 5'h0};
	logic [4:0] sc = 0, drv, fst, lcur, loc;
	int error_cnt = 0, checked = 0, cyc = 0, exp, seed = 32'hca22, i, k;
	fault_shutdown uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .deglitched_control_input(din),
		.supply_undervoltage(shf[0]), .charge_pump_failure(shf[1]),
		.overtemp_shutdown(shf[2]), .offstate_open_load(olo),
		.high_current_window_first(src[0]),
		.high_current_window_second(src[1]),
		.high_current_window_third(src[2]),
		.low_overcurrent_threshold(src[3] | loc),
		.channel_overtemp(src[4]), .severe_short_detect(src[5]),
		.load_current_present(lcur), .channel_drive_command(drv),
		.fast_turnoff_path(fst), .second_window_slow(sws), .irq(irq));
	lamp_load load (.drive(drv), .short_cmd(sc), .current_present(lcur),
		.overcurrent(loc));
	initial forever #5 pclk = ~pclk;
	task results;
		$display("checked=%0d mismatches=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		// Host reference clock at 100 kHz; no pin of the block takes it
		ref_pwm <= (cyc % 500 == 0) ? ~ref_pwm : ref_pwm;
		if (cyc == 30000) begin
			error_cnt++;
			results();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	initial begin
		tick(5);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `ADDR_CTRL, 0);
		chk(rd, 0);
		chk(sws, 'h1f);
		apb(0, 12'h020, 0);
		chk(er, 1);
		apb(1, `ADDR_ON, 32'h1f);
		tick(4);
		chk(drv, 'h1f);
		apb(1, `ADDR_IRQ_MASK, 32'hffffffff);
		for (i = 0; i < 6; i++) begin
			k = i % 5;
			src[i][k] <= 1;
			tick(80);
			exp = 'h1f & ~(1 << k);
			chk(drv, exp);
			apb(0, `ADDR_DRIVE, 0);
			chk(rd, (1 << (k + 5)) | exp);
			chk(irq, 1);
			apb(0, `ADDR_QSTAT, 0);
			chk(rd[0], 1);
			apb(0, `ADDR_CHSTAT, 0);
			chk(rd, 1 << k);
			src[i][k] <= 0;
			tick(80);
			chk(drv, exp);
			apb(1, `ADDR_IRQ_STAT, 32'hffffffff);
			chk(irq, 0);
			apb(1, `ADDR_ON, 32'h1f);
			tick(4);
			chk(drv, 'h1f);
		end
		$display("normal faults done");
		apb(1, `ADDR_IRQ_MASK, 0);
		for (i = 0; i < 3; i++) begin
			shf[i] <= 1;
			tick(80);
			chk(drv, 0);
			chk(irq, 0);
			apb(0, `ADDR_DRIVE, 0);
			chk(rd, 32'h3e0);
			apb(1, `ADDR_CTRL, 2 * i + 2);
			chk(sws, (i == 0) ? 'h4 : (i == 1) ? 'hc : 0);
			shf[i] <= 0;
			tick(80);
			apb(1, `ADDR_ON, 32'h1f);
			tick(4);
			chk(drv, 'h1f);
		end
		$display("shared faults done");
		// Profile bits set too: fail mode must still slow every channel without load current
		apb(1, `ADDR_CTRL, 32'h7);
		repeat (4) begin
			din <= 4'($random(seed));
			tick(6);
			chk(drv, {1'b0, din});
		end
		din <= 4'hf;
		tick(6);
		chk(sws, 'h10);
		sc[0] <= 1;
		src[5][1] <= 1;
		olo[4] <= 1;
		tick(80);
		sc[0] <= 0;
		src[5][1] <= 0;
		chk(drv, 'hc);
		chk(fst, 'h13);
		apb(0, `ADDR_DRIVE, 0);
		chk(rd, 32'h26c);
		olo[4] <= 0;
		tick(4200);
		chk(drv, 'hd);
		apb(1, `ADDR_CTRL, 0);
		apb(1, `ADDR_CTRL, 1);
		tick(6);
		chk(drv, 'hf);
		$display("fail mode done");
		results();
	end
endmodule // tb_output_fault_shutdown_restart
